// ==== hdl/spg_config_top.sv ====
// module: persistence filters, wait stretch and proximity gain configuration registers
//
// Summary of operation
// RL1: prox_persist_code lives in persistence_filter bits 7:4, reset zero.
// RL2: prox code 0 interrupts every cycle; code 1 on any out-of-range result.
// RL3: prox codes 2..15 need that many consecutive out-of-range results.
// RL4: count consecutive out-of-range prox results; interrupt when count equals code.
// RL5: an in-window prox result clears the prox counter.
// RL6: light_persist_code lives in persistence_filter bits 3:0, reset zero.
// RL7: light codes 0 and 1 trigger on one result; codes 2, 3 need 2, 3.
// RL8: light codes 4..15 need five times (code minus 3) results, 5 to 60.
// RL9: count consecutive out-of-range light results; interrupt when count matches target.
// RL10: an in-window light result clears the light counter.
// RL11: config bit 7 with auto pulse control gives a 16-bit prox result; resets zero.
// RL12: prox_wait_stretch (config bit 3) multiplies prox wait by 12.
// RL13: light_wait_stretch (config bit 2) multiplies light wait by 12.
// RL14: host writes reserved bits with defaults: config 6:4=001, 1:0=00, gain 4:2=000.
// RL15: prox_stage1_gain in bits 7:5, reset 010; codes 0..4 give 1x to 16x.
// RL16: prox_stage2_gain in bits 1:0, reset 11; 0=2.5x, 1=5x, 3=10x.
// RL17: host never writes stage-two gain code 2.
// RL18: prox result out of range when below low or above high 14-bit threshold.
// RL19: light match sets light_irq_flag; with light_irq_enable it drives the interrupt pin.
// RL20: persistence counters saturate at their maximum count instead of wrapping.
`timescale 1ns/100ps
module spg_config_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    // proximity result path
    input wire logic proxResultValid,
    input wire logic [13:0] proxResult,
    input wire logic [13:0] proxLowThresh,
    input wire logic [13:0] proxHighThresh,
    // light clear-channel result path
    input wire logic lightResultValid,
    input wire logic [15:0] lightResult,
    input wire logic [15:0] lightLowThresh,
    input wire logic [15:0] lightHighThresh,
    // interrupt control
    input wire logic proxIrqEnable,
    input wire logic lightIrqEnable,
    input wire logic proxIrqClear,
    input wire logic lightIrqClear,
    output logic proxIrqFlag,
    output logic lightIrqFlag,
    output logic intPin,
    // configuration outputs and the auto pulse control input
    input wire logic autoPulseControl,
    output logic wideProxOutputEn,
    output logic [3:0] proxWaitFactor,
    output logic [3:0] lightWaitFactor,
    output logic [2:0] proxStage1Gain,
    output logic [4:0] proxStage1Mult,
    output logic [1:0] proxStage2Gain
);
    logic [7:0] persist_q;
    logic [7:0] persist_d;
    logic [7:0] genCfg_q;
    logic [7:0] genCfg_d;
    logic [7:0] gainCfg_q;
    logic [7:0] gainCfg_d;
    logic [7:0] rdData_q;
    logic [7:0] rdData_d;
    logic proxFlag_q;
    logic proxFlag_d;
    logic lightFlag_q;
    logic lightFlag_d;
    logic [3:0] proxCode;
    logic [3:0] lightCode;
    logic [5:0] lightTarget;

    spg_persistence_filter_if proxCh ();
    spg_persistence_filter_if lightCh ();

    // register file: reserved bits are stored as written, the host keeps them at defaults
    always_comb begin
        persist_d = persist_q;
        genCfg_d = genCfg_q;
        gainCfg_d = gainCfg_q;
        rdData_d = rdData_q;
        if (regWrEn) begin
            case (regAddr)
                spg_pkg::ADDR_PERSISTENCE_FILTER: persist_d = regWrData; // see RL1 see RL6
                spg_pkg::ADDR_GENERAL_CONFIG: genCfg_d = regWrData; // see RL12 see RL13
                spg_pkg::ADDR_PROXIMITY_GAIN_CONFIG: gainCfg_d = regWrData; // see RL15 see RL16
                default: persist_d = persist_q;
            endcase
        end
        if (regRdEn) begin
            case (regAddr)
                spg_pkg::ADDR_PERSISTENCE_FILTER: rdData_d = persist_q;
                spg_pkg::ADDR_GENERAL_CONFIG: rdData_d = genCfg_q;
                spg_pkg::ADDR_PROXIMITY_GAIN_CONFIG: rdData_d = gainCfg_q;
                default: rdData_d = spg_pkg::UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            persist_q <= spg_pkg::RST_PERSISTENCE_FILTER; // see RL1 see RL6
            genCfg_q <= spg_pkg::RST_GENERAL_CONFIG; // see RL11
            gainCfg_q <= spg_pkg::RST_PROXIMITY_GAIN_CONFIG; // see RL15 see RL16
            rdData_q <= spg_pkg::UNMAPPED_READ;
        end else begin
            persist_q <= persist_d;
            genCfg_q <= genCfg_d;
            gainCfg_q <= gainCfg_d;
            rdData_q <= rdData_d;
        end
    end

    assign regRdData = rdData_q;

    // persistence codes and targets
    assign proxCode = persist_q[spg_pkg::PROX_PERSIST_MSB:spg_pkg::PROX_PERSIST_LSB];
    assign lightCode = persist_q[spg_pkg::LIGHT_PERSIST_MSB:spg_pkg::LIGHT_PERSIST_LSB];

    always_comb begin
        if (lightCode <= spg_pkg::LIGHT_LINEAR_LAST) begin
            // codes 0 and 1 both mean a single result
            lightTarget = (lightCode < 4'h2) ? spg_pkg::LIGHT_SINGLE : {2'h0, lightCode}; // see RL7
        end else begin
            lightTarget = 6'({2'h0, lightCode - spg_pkg::LIGHT_LINEAR_LAST} * spg_pkg::LIGHT_STEP); // see RL8
        end
    end

    // proximity channel: code 0 matches on every valid result, code n needs n in a row
    assign proxCh.sampleValid = proxResultValid;
    assign proxCh.outOfRange = (proxResult < proxLowThresh) || (proxResult > proxHighThresh); // see RL18
    assign proxCh.everyCycle = (proxCode == 4'h0); // see RL2
    assign proxCh.target = {2'h0, proxCode}; // see RL3

    assign lightCh.sampleValid = lightResultValid;
    assign lightCh.outOfRange = (lightResult < lightLowThresh) || (lightResult > lightHighThresh);
    assign lightCh.everyCycle = 1'b0;
    assign lightCh.target = lightTarget; // see RL9

    spg_persistence_filter_counter #(.CNT_MAX(spg_pkg::PROX_CNT_MAX)) proxCounter (
        .clk(clk),
        .rst(rst),
        .ch(proxCh.cnt)
    );

    spg_persistence_filter_counter #(.CNT_MAX(spg_pkg::LIGHT_CNT_MAX)) lightCounter (
        .clk(clk),
        .rst(rst),
        .ch(lightCh.cnt)
    );

    // sticky flags: a match in the clear cycle wins so no event is lost
    always_comb begin
        proxFlag_d = proxCh.match | (proxFlag_q & ~proxIrqClear); // see RL4
        lightFlag_d = lightCh.match | (lightFlag_q & ~lightIrqClear); // see RL19
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            proxFlag_q <= 1'b0;
            lightFlag_q <= 1'b0;
        end else begin
            proxFlag_q <= proxFlag_d;
            lightFlag_q <= lightFlag_d;
        end
    end

    assign proxIrqFlag = proxFlag_q;
    assign lightIrqFlag = lightFlag_q;
    assign intPin = (lightFlag_q & lightIrqEnable) | (proxFlag_q & proxIrqEnable); // see RL19

    // configuration decode; wide output only counts while auto pulse control runs
    assign wideProxOutputEn = genCfg_q[spg_pkg::WIDE_PROX_OUT_BIT] & autoPulseControl; // see RL11
    assign proxWaitFactor = genCfg_q[spg_pkg::PROX_WAIT_STRETCH_BIT] ?
        spg_pkg::WAIT_FACTOR_LONG : spg_pkg::WAIT_FACTOR_NORMAL; // see RL12
    assign lightWaitFactor = genCfg_q[spg_pkg::LIGHT_WAIT_STRETCH_BIT] ?
        spg_pkg::WAIT_FACTOR_LONG : spg_pkg::WAIT_FACTOR_NORMAL; // see RL13
    assign proxStage1Gain = gainCfg_q[spg_pkg::STAGE1_GAIN_MSB:spg_pkg::STAGE1_GAIN_LSB];
    // codes above 4 are undefined; they read back but give no gain
    assign proxStage1Mult = (proxStage1Gain <= spg_pkg::STAGE1_GAIN_LAST) ?
        5'(5'h01 << proxStage1Gain) : 5'h00; // see RL15
    assign proxStage2Gain = gainCfg_q[spg_pkg::STAGE2_GAIN_MSB:spg_pkg::STAGE2_GAIN_LSB]; // see RL16
endmodule : spg_config_top

// ==== hdl/spg_pkg.sv ====
// package: register map, field layout and reset values of the persistence and gain block
package spg_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_PERSISTENCE_FILTER = 8'h8c;
    localparam logic [7:0] ADDR_GENERAL_CONFIG = 8'h8d;
    localparam logic [7:0] ADDR_PROXIMITY_GAIN_CONFIG = 8'h8e;
    // reset values
    localparam logic [7:0] RST_PERSISTENCE_FILTER = 8'h00;
    localparam logic [7:0] RST_GENERAL_CONFIG = 8'h10;
    localparam logic [7:0] RST_PROXIMITY_GAIN_CONFIG = 8'h43;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // persistence_filter fields
    localparam int PROX_PERSIST_MSB = 7;
    localparam int PROX_PERSIST_LSB = 4;
    localparam int LIGHT_PERSIST_MSB = 3;
    localparam int LIGHT_PERSIST_LSB = 0;
    // general_config fields
    localparam int WIDE_PROX_OUT_BIT = 7;
    localparam int PROX_WAIT_STRETCH_BIT = 3;
    localparam int LIGHT_WAIT_STRETCH_BIT = 2;
    // proximity_gain_config fields
    localparam int STAGE1_GAIN_MSB = 7;
    localparam int STAGE1_GAIN_LSB = 5;
    localparam int STAGE2_GAIN_MSB = 1;
    localparam int STAGE2_GAIN_LSB = 0;
    // persistence counting
    localparam int CNT_W = 6;
    localparam logic [5:0] PROX_CNT_MAX = 6'h0f;
    localparam logic [5:0] LIGHT_CNT_MAX = 6'h3c;
    localparam logic [3:0] LIGHT_LINEAR_LAST = 4'h3;
    localparam logic [5:0] LIGHT_STEP = 6'h05;
    localparam logic [5:0] LIGHT_SINGLE = 6'h01;
    // wait stretch factors
    localparam logic [3:0] WAIT_FACTOR_LONG = 4'hc;
    localparam logic [3:0] WAIT_FACTOR_NORMAL = 4'h1;
    // first stage gain table: codes 0..4 are powers of two
    localparam logic [2:0] STAGE1_GAIN_LAST = 3'h4;
    // threshold widths
    localparam int PROX_W = 14;
    localparam int LIGHT_W = 16;
endpackage : spg_pkg

// ==== hdl/spg_persistence_filter_if.sv ====
// interface: one persistence filter channel between the config top and a counter
`timescale 1ns/100ps
interface spg_persistence_filter_if;
    logic sampleValid;
    logic outOfRange;
    logic everyCycle;
    logic [spg_pkg::CNT_W-1:0] target;
    logic match;
    modport ctl (output sampleValid, output outOfRange, output everyCycle, output target,
        input match);
    modport cnt (input sampleValid, input outOfRange, input everyCycle, input target,
        output match);
endinterface : spg_persistence_filter_if

// ==== hdl/spg_persistence_filter_counter.sv ====
// module: consecutive out-of-range counter of one persistence filter
`timescale 1ns/100ps
module spg_persistence_filter_counter #(
    parameter logic [5:0] CNT_MAX = 6'h0f
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // channel
    spg_persistence_filter_if.cnt ch
);
    logic [spg_pkg::CNT_W-1:0] count_q;
    logic [spg_pkg::CNT_W-1:0] count_d;
    logic [spg_pkg::CNT_W-1:0] countInc;
    logic match_q;
    logic match_d;

    always_comb begin
        count_d = count_q;
        match_d = 1'b0;
        // saturate instead of wrapping: a long run keeps matching the same way
        countInc = (count_q == CNT_MAX) ? count_q : count_q + 6'h01; // see RL20
        if (ch.sampleValid) begin
            if (ch.everyCycle) begin
                match_d = 1'b1; // see RL2
            end
            if (ch.outOfRange) begin
                count_d = countInc; // see RL4 see RL9
                if (countInc == ch.target) begin
                    match_d = 1'b1; // see RL3 see RL4 see RL9
                end
            end else begin
                count_d = '0; // see RL5 see RL10
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q <= '0;
            match_q <= 1'b0;
        end else begin
            count_q <= count_d;
            match_q <= match_d;
        end
    end

    assign ch.match = match_q;
endmodule : spg_persistence_filter_counter

// ==== testbench/spg_host_model.sv ====
// host model: register writes and reads on the strobe port
`timescale 1ns/100ps
module spg_host_model (
    // register port
    input wire logic clk,
    output logic [7:0] regAddr,
    output logic regWrEn,
    output logic [7:0] regWrData,
    output logic regRdEn,
    input wire logic [7:0] regRdData
);
    initial begin
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        regRdEn = 1'b0;
    end
    // reserved bits are forced to defaults, so a careless caller cannot break them
    function automatic logic [7:0] legal(input logic [7:0] a, input logic [7:0] d);
        if (a == 8'h8d) return {d[7], 3'h1, d[3:2], 2'h0};
        if (a == 8'h8e) return {d[7:5], 3'h0, (d[1:0] == 2'h2) ? 2'h3 : d[1:0]};
        return d;
    endfunction : legal
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        regAddr = a;
        regWrData = legal(a, d);
        regWrEn = 1'b1;
        @(posedge clk);
        #1;
        regWrEn = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        regAddr = a;
        regRdEn = 1'b1;
        @(posedge clk);
        #1;
        regRdEn = 1'b0;
        d = regRdData;
    endtask : rd
endmodule : spg_host_model

// ==== testbench/spg_config_properties.sv ====
// checker: port assertions of the persistence and gain block
`timescale 1ns/100ps
module spg_config_properties (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    // results
    input wire logic proxResultValid,
    input wire logic lightResultValid,
    input wire logic [15:0] lightResult,
    input wire logic [15:0] lightLowThresh,
    input wire logic [15:0] lightHighThresh,
    // interrupts
    input wire logic proxIrqEnable,
    input wire logic lightIrqEnable,
    input wire logic proxIrqFlag,
    input wire logic lightIrqFlag,
    input wire logic intPin,
    // configuration
    input wire logic autoPulseControl,
    input wire logic wideProxOutputEn,
    input wire logic [3:0] proxWaitFactor,
    input wire logic [3:0] lightWaitFactor,
    input wire logic [2:0] proxStage1Gain,
    input wire logic [4:0] proxStage1Mult,
    input wire logic [1:0] proxStage2Gain
);
    logic [7:0] persD;
    logic [7:0] persQ;
    logic lightOut;
    // shadow of persistence_filter, so codes are known without peeking inside
    always_comb persD = (regWrEn && regAddr == 8'h8c) ? regWrData : persQ;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            persQ <= 8'h00;
        end else begin
            persQ <= persD;
        end
    end
    assign lightOut = lightResult < lightLowThresh || lightResult > lightHighThresh;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_PROX_CODE0: assert property (proxResultValid && persQ[7:4] == 4'h0 |-> ##[2:3] proxIrqFlag)
        else $error("prox code 0 gave no flag");
    AST_LIGHT_SINGLE: assert property (
        lightResultValid && persQ[3:0] <= 4'h1 && lightOut |-> ##[2:3] lightIrqFlag)
        else $error("light single result gave no flag");
    AST_LIGHT_CAUSE: assert property (
        $rose(lightIrqFlag) |-> $past(lightResultValid, 2) || $past(lightResultValid, 3))
        else $error("light flag rose without result");
    AST_INT_PIN: assert property (
        intPin == ((proxIrqFlag && proxIrqEnable) || (lightIrqFlag && lightIrqEnable)))
        else $error("interrupt pin mismatch");
    AST_WIDE: assert property (wideProxOutputEn |-> autoPulseControl)
        else $error("wide output without pulse control");
    AST_PWAIT: assert property (
        regWrEn && regAddr == 8'h8d |=> proxWaitFactor == ($past(regWrData[3]) ? 4'hc : 4'h1))
        else $error("prox wait factor wrong");
    AST_LWAIT: assert property (
        regWrEn && regAddr == 8'h8d |=> lightWaitFactor == ($past(regWrData[2]) ? 4'hc : 4'h1))
        else $error("light wait factor wrong");
    AST_MULT: assert property (
        proxStage1Mult == ((proxStage1Gain <= 3'h4) ? (5'h01 << proxStage1Gain) : 5'h00))
        else $error("stage one multiplier wrong");
    AST_GAIN_WR: assert property (
        regWrEn && regAddr == 8'h8e |=>
        proxStage2Gain == $past(regWrData[1:0]) && proxStage1Gain == $past(regWrData[7:5]))
        else $error("gain fields not stored");
    COV_PROX: cover property ($rose(proxIrqFlag));
    COV_LIGHT: cover property ($rose(lightIrqFlag));
    COV_WIDE: cover property ($rose(wideProxOutputEn));
endmodule : spg_config_properties
bind spg_config_top spg_config_properties u_spg_config_properties (.*);

// ==== testbench/testbench.sv ====
// testbench: register, persistence and gain scenarios
`timescale 1ns/100ps
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr, regWrData, regRdData, rdv;
    logic regWrEn, regRdEn, proxIrqFlag, lightIrqFlag, intPin, wideProxOutputEn;
    logic proxResultValid = 1'b0;
    logic lightResultValid = 1'b0;
    logic [13:0] proxResult = 14'h0000;
    logic [15:0] lightResult = 16'h0000;
    logic [13:0] proxLowThresh = 14'h0100;
    logic [13:0] proxHighThresh = 14'h0200;
    logic [15:0] lightLowThresh = 16'h0100;
    logic [15:0] lightHighThresh = 16'h0200;
    logic proxIrqEnable = 1'b1;
    logic lightIrqEnable = 1'b1;
    logic proxIrqClear = 1'b0;
    logic lightIrqClear = 1'b0;
    logic autoPulseControl = 1'b0;
    logic [3:0] proxWaitFactor, lightWaitFactor;
    logic [2:0] proxStage1Gain;
    logic [4:0] proxStage1Mult;
    logic [1:0] proxStage2Gain, s2v;
    logic [3:0] lc [4] = '{4'h0, 4'h2, 4'h4, 4'hf};
    int ln [4] = '{1, 2, 5, 60};
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    spg_config_top u_spg_config_top (.*);
    spg_host_model u_spg_host_model (.*);
    always #25 clk = ~clk;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic final_report;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    // one-cycle result pulses with a gap, then time for the flag to land
    task automatic send(input logic isProx, input logic [15:0] v, input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
            proxResultValid = isProx;
            lightResultValid = !isProx;
            proxResult = v[13:0];
            lightResult = v;
            @(posedge clk);
            #1;
            proxResultValid = 1'b0;
            lightResultValid = 1'b0;
        end
        repeat (4) @(posedge clk);
        #1;
    endtask : send
    task automatic clr;
        @(posedge clk);
        #1;
        proxIrqClear = 1'b1;
        lightIrqClear = 1'b1;
        @(posedge clk);
        #1;
        proxIrqClear = 1'b0;
        lightIrqClear = 1'b0;
    endtask : clr
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            final_report();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        u_spg_host_model.rd(8'h8c, rdv);
        chk(rdv, 8'h00);
        u_spg_host_model.rd(8'h8d, rdv);
        chk(rdv, 8'h10);
        u_spg_host_model.rd(8'h8e, rdv);
        chk(rdv, 8'h43);
        u_spg_host_model.rd(8'h8f, rdv);
        chk(rdv, 8'h00);
        chk({pwfDummy(), lightWaitFactor}, 8'h11);
        autoPulseControl = 1'b1;
        u_spg_host_model.wr(8'h8d, 8'h88);
        chk({wideProxOutputEn, 3'h0, proxWaitFactor}, 8'h8c);
        autoPulseControl = 1'b0;
        #1;
        chk(wideProxOutputEn, 8'h00);
        u_spg_host_model.wr(8'h8d, 8'h04);
        chk({wideProxOutputEn, 3'h0, lightWaitFactor}, 8'h0c);
        u_spg_host_model.rd(8'h8d, rdv);
        chk(rdv, 8'h14);
        for (int c = 0; c < 5; c++) begin
            s2v = (c % 3 == 2) ? 2'h3 : 2'(c % 3);
            u_spg_host_model.wr(8'h8e, {c[2:0], 3'h0, (c == 4) ? 2'h2 : s2v});
            chk({3'h0, proxStage1Mult}, 8'h01 << c);
            chk({proxStage1Gain, 3'h0, proxStage2Gain}, {c[2:0], 3'h0, (c == 4) ? 2'h3 : s2v});
        end
        u_spg_host_model.wr(8'h8c, 8'h30);
        clr();
        send(1'b1, 16'h0000, 2);
        send(1'b1, 16'h0150, 1);
        send(1'b1, 16'h0000, 2);
        chk(proxIrqFlag, 8'h00);
        send(1'b1, 16'h0000, 1);
        chk({proxIrqFlag, intPin}, 8'h03);
        u_spg_host_model.wr(8'h8c, 8'h00);
        clr();
        send(1'b1, 16'h0150, 1);
        chk(proxIrqFlag, 8'h01);
        u_spg_host_model.wr(8'h8c, 8'h10);
        clr();
        send(1'b1, 16'h3fff, 1);
        chk(proxIrqFlag, 8'h01);
        for (int i = 0; i < 4; i++) begin
            u_spg_host_model.wr(8'h8c, {4'h0, lc[i]});
            send(1'b0, 16'h0150, 1);
            clr();
            send(1'b0, 16'h0000, ln[i] - 1);
            send(1'b0, 16'h0150, 1);
            send(1'b0, 16'h0000, ln[i] - 1);
            chk(lightIrqFlag, 8'h00);
            send(1'b0, 16'h0300, 1);
            chk(lightIrqFlag, 8'h01);
        end
        clr();
        send(1'b0, 16'h0000, 1);
        chk({lightIrqFlag, intPin}, 8'h03);
        lightIrqEnable = 1'b0;
        #1;
        chk(intPin, 8'h00);
        final_report();
    end
    function automatic logic [3:0] pwfDummy();
        return proxWaitFactor;
    endfunction : pwfDummy
endmodule : testbench
